// ---- fw_boot_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module fw_boot_device
  import fw_boot_pkg::*;
#(
  parameter logic [31:0] ACTIVATION_CODE = 32'h1234_5678,
  parameter logic [15:0] PRODUCT_ID      = 16'h00A5, // arbitrary value
  parameter int          PHASE_CYC       = TX_PHASE_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  fw_link_if.device        link,
  output logic             mem_req_o,
  input  wire logic [15:0] mem_data_i,
  input  wire logic        mem_valid_i,
  input  wire logic        rx_sync_i,
  input  wire logic [15:0] rx_word_i,
  input  wire logic        rx_word_valid_i,
  output logic [15:0]      tx_word_o,
  output logic             tx_word_valid_o,
  output tx_e              tx_phase_o,
  output modem_mode_e      mode_o,
  output logic             ready_o
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  if (PHASE_CYC < 1 || PHASE_CYC > 256) begin : g_bad_phase
    $error("PHASE_CYC out of range");
  end

  localparam logic [7:0] PH_LAST = 8'(PHASE_CYC - 1);

  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [1:0]  sel_s;
    logic [1:0]  cmd_s;
    logic [1:0]  b1_s;
    logic [1:0]  b2_s;
    logic [1:0]  smp;
    boot_e       boot;
    logic [4:0]  bitcnt;
    logic [15:0] shin;
    logic [15:0] shout;
    logic [7:0]  addr;
    logic        rd_act;
    logic        reply;
    logic        irq_n;
    logic        len_ok;
    logic [14:0] img_len;
    logic [14:0] img_cnt;
    logic [31:0] sum1;
    logic [31:0] sum2;
    logic [15:0] version;
    logic [15:0] ident;
    logic [15:0] act_hi;
    logic        act_half;
    modem_mode_e mode;
    logic [15:0] pwr;
    logic [15:0] mask;
    logic [15:0] rxctl;
    logic [15:0] transmit_data_regs;
    logic [15:0] receive_data_regs;
    logic        tx_full;
    logic        program_write_accepted_flag;
    logic        rdy;
    logic        rx_lock;
    logic        mem_req;
    logic        ready;
    tx_e         txph;
    logic [7:0]  ph_cnt;
    logic [15:0] tx_word;
    logic        tx_valid;
  } dev_s;

  dev_s        r_r;
  dev_s        r_nxt;
  logic        rise;
  logic        fall;
  logic        wr_stb;
  logic        word_stb;
  logic [15:0] word_val;
  logic [15:0] wdata;
  logic        gen_rst;
  logic        active;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] read_mux(input dev_s s, input logic [7:0] a);
    case (a)
      A_SUM1_HI: read_mux = s.sum1[31:16];
      A_SUM1_LO: read_mux = s.sum1[15:0];
      A_SUM2_HI: read_mux = (s.boot == BT_RUN) ? s.receive_data_regs : s.sum2[31:16];
      A_SUM2_LO: read_mux = s.sum2[15:0];
      A_IDENT:   read_mux = s.ident;
      A_VERSION: read_mux = s.version;
      A_STATUS:  read_mux = {~s.irq_n, 13'h0000, s.rdy, s.program_write_accepted_flag};
      default:   read_mux = 16'h0000;
    endcase
  endfunction : read_mux

  function automatic logic prog_open(input dev_s s);
    prog_open = (s.boot == BT_HOST) || (s.boot == BT_ACT) ||
                (s.boot == BT_RUN && s.mode == MD_IDLE);
  endfunction : prog_open

  function automatic tx_e tx_next(input tx_e p);
    case (p)
      TX_RAMPUP: tx_next = TX_PRE;
      TX_PRE:    tx_next = TX_SYNC;
      TX_SYNC:   tx_next = TX_PAY;
      TX_TAIL:   tx_next = TX_RAMPDN;
      default:   tx_next = TX_OFF;
    endcase
  endfunction : tx_next

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_nxt    = r_r;
    wr_stb   = 1'b0;
    word_stb = 1'b0;
    word_val = 16'h0000;
    gen_rst  = 1'b0;
    r_nxt.sclk_s   = {r_r.sclk_s[1:0], link.sclk};
    r_nxt.sel_s    = {r_r.sel_s[0], link.sel_n};
    r_nxt.cmd_s    = {r_r.cmd_s[0], link.cmd_data};
    r_nxt.b1_s     = {r_r.b1_s[0], link.boot_source_pin_one};
    r_nxt.b2_s     = {r_r.b2_s[0], link.boot_source_pin_two};
    r_nxt.tx_valid = 1'b0;
    rise   = r_r.sclk_s[1] & ~r_r.sclk_s[2];
    fall   = ~r_r.sclk_s[1] & r_r.sclk_s[2];
    wdata  = {r_r.shin[14:0], r_r.cmd_s[1]};
    active = (r_r.boot == BT_RUN) && r_r.pwr[PWR_BIAS];

    // serial framing, msb first
    if (r_r.sel_s[1]) begin
      r_nxt.bitcnt = 5'd0;
      r_nxt.rd_act = 1'b0;
      r_nxt.reply  = 1'b0;
    end else if (rise) begin
      r_nxt.shin   = wdata;
      r_nxt.bitcnt = (r_r.bitcnt == 5'd31) ? r_r.bitcnt : r_r.bitcnt + 5'd1;
      if (r_r.bitcnt == 5'(ADDR_BITS - 1)) begin
        r_nxt.addr = wdata[7:0];
        if (wdata[7:0] == CMD_GENERAL_RESET) begin
          gen_rst = 1'b1;
        end else begin
          r_nxt.rd_act = 1'b1;
          r_nxt.shout  = read_mux(r_r, wdata[7:0]);
          case (wdata[7:0])
            A_SUM1_HI, A_SUM1_LO, A_SUM2_HI, A_SUM2_LO, A_IDENT, A_VERSION, A_STATUS: r_nxt.rd_act = 1'b1;
            default: r_nxt.rd_act = 1'b0;
          endcase
          if (wdata[7:0] == A_STATUS) r_nxt.rdy = 1'b0; // read clears rdy only, not accepted
          if (wdata[7:0] == A_PROGRAM && prog_open(r_r)) r_nxt.program_write_accepted_flag = 1'b0;
        end
      end
      if (r_r.bitcnt == 5'(FRAME_BITS - 1) && !r_r.rd_act) wr_stb = 1'b1;
    end else if (fall && r_r.rd_act) begin
      r_nxt.reply = r_r.shout[15];
      r_nxt.shout = {r_r.shout[14:0], 1'b0};
    end

    // boot source sampled once after reset
    if (r_r.boot == BT_SAMPLE) begin
      r_nxt.smp = r_r.smp + 2'd1;
      if (r_r.smp == 2'(SAMPLE_WAIT)) begin
        if (r_r.b1_s[1] && r_r.b2_s[1]) r_nxt.boot = BT_HOST;
        else if (r_r.b1_s[1]) r_nxt.boot = BT_MEM;
        else r_nxt.boot = BT_DEAD;
      end
    end

    // register writes
    if (wr_stb) begin
      case (r_r.addr)
        A_PROGRAM: begin
          if (r_r.boot == BT_HOST) begin
            word_stb  = 1'b1;
            word_val  = wdata;
            r_nxt.program_write_accepted_flag = 1'b1;
          end else if (r_r.boot == BT_ACT) begin
            r_nxt.program_write_accepted_flag = 1'b1;
            if (!r_r.act_half) begin
              r_nxt.act_hi   = wdata;
              r_nxt.act_half = 1'b1;
            end else if ({r_r.act_hi, wdata} == ACTIVATION_CODE) begin
              r_nxt.boot    = BT_RUN;
              r_nxt.ready   = 1'b1;
              r_nxt.mode    = MD_IDLE;
              r_nxt.sum1    = '0;
              r_nxt.sum2    = '0;
              r_nxt.ident   = '0;
              r_nxt.version = '0;
            end else begin
              r_nxt.sum1[31:16] = DEAD_CODE;
              r_nxt.boot        = BT_DEAD;
            end
          end else if (prog_open(r_r)) begin
            r_nxt.program_write_accepted_flag = 1'b1;
          end
        end
        A_MODE:   if (r_r.boot == BT_RUN) r_nxt.mode = modem_mode_e'(wdata[1:0]);
        A_POWER:  r_nxt.pwr = wdata;
        A_RXCTL:  r_nxt.rxctl = wdata;
        A_MASK:   r_nxt.mask = wdata;
        A_TRANSMIT_DATA_REGS: begin
          r_nxt.transmit_data_regs  = wdata;
          r_nxt.tx_full = 1'b1;
        end
        default: ;
      endcase
    end

    // serial memory source
    if (r_r.boot == BT_MEM) begin
      r_nxt.mem_req = 1'b1;
      if (r_r.mem_req && mem_valid_i) begin
        word_stb = 1'b1;
        word_val = mem_data_i;
      end
    end

    // image words: length first, then body
    if (word_stb) begin
      if (!r_r.len_ok) begin
        if (word_val == 16'h0000 || word_val > 16'(IMAGE_MAX_WORDS)) begin
          r_nxt.boot    = BT_DEAD;
          r_nxt.mem_req = 1'b0;
        end else begin
          r_nxt.img_len = word_val[14:0];
          r_nxt.len_ok  = 1'b1;
        end
      end else begin
        if (r_r.img_cnt == 15'd0) r_nxt.version = word_val;
        r_nxt.sum1    = r_r.sum1 + {16'h0000, word_val};
        r_nxt.sum2    = {r_r.sum2[30:0], r_r.sum2[31]} ^ {16'h0000, word_val};
        r_nxt.img_cnt = r_r.img_cnt + 15'd1;
        if (r_r.img_cnt == r_r.img_len - 15'd1) begin
          r_nxt.boot    = BT_ACT;
          r_nxt.ident   = PRODUCT_ID;
          r_nxt.mem_req = 1'b0;
        end
      end
    end

    // transmit burst sequence
    case (r_r.txph)
      TX_OFF: begin
        r_nxt.ph_cnt = 8'h00;
        if (active && r_r.mode == MD_TX) r_nxt.txph = TX_RAMPUP;
      end
      TX_PAY: begin
        if (!(active && r_r.mode == MD_TX)) begin
          r_nxt.txph = TX_TAIL;
        end else if (r_r.tx_full) begin
          r_nxt.tx_word  = r_r.transmit_data_regs;
          r_nxt.tx_valid = 1'b1;
          r_nxt.tx_full  = 1'b0;
          r_nxt.rdy      = 1'b1;
        end
      end
      default: begin
        r_nxt.ph_cnt = r_r.ph_cnt + 8'h01;
        if (r_r.ph_cnt == PH_LAST) begin
          r_nxt.ph_cnt = 8'h00;
          r_nxt.txph   = tx_next(r_r.txph);
        end
      end
    endcase

    // receive: lock on sync, stream blocks
    if (active && (r_r.mode == MD_RX || r_r.mode == MD_CS)) begin
      if (rx_sync_i) r_nxt.rx_lock = 1'b1;
      if (r_r.rx_lock && rx_word_valid_i) begin
        r_nxt.receive_data_regs = rx_word_i;
        r_nxt.rdy    = 1'b1;
      end
    end else begin
      r_nxt.rx_lock = 1'b0;
    end

    // masked interrupt from sticky flags
    r_nxt.irq_n = ~(r_r.mask[MASK_ALL] & |({r_r.rdy, r_r.program_write_accepted_flag} & r_r.mask[1:0]));

    // general reset restarts the boot
    if (gen_rst) begin
      r_nxt.boot     = BT_SAMPLE;
      r_nxt.smp      = 2'd0;
      r_nxt.len_ok   = 1'b0;
      r_nxt.img_cnt  = '0;
      r_nxt.sum1     = '0;
      r_nxt.sum2     = '0;
      r_nxt.ident    = '0;
      r_nxt.version  = '0;
      r_nxt.act_half = 1'b0;
      r_nxt.mode     = MD_IDLE;
      r_nxt.txph     = TX_OFF;
      r_nxt.mem_req  = 1'b0;
      r_nxt.ready    = 1'b0;
      r_nxt.program_write_accepted_flag      = 1'b0;
      r_nxt.rdy      = 1'b0;
      r_nxt.tx_full  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r_r       <= '0;
      r_r.irq_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs
  assign link.reply_data               = r_r.reply;
  assign link.interrupt_request_line_n = r_r.irq_n;
  assign mem_req_o                     = r_r.mem_req;
  assign tx_word_o                     = r_r.tx_word;
  assign tx_word_valid_o               = r_r.tx_valid;
  assign tx_phase_o                    = r_r.txph;
  assign mode_o                        = r_r.mode;
  assign ready_o                       = r_r.ready;
endmodule : fw_boot_device
`default_nettype wire

// ---- fw_boot_pkg.sv ----
`default_nettype none
package fw_boot_pkg;
  // ----------------------------------------
  // device register map
  // ----------------------------------------
  localparam logic [7:0] A_SUM1_HI         = 8'hA9;
  localparam logic [7:0] A_SUM1_LO         = 8'hAA;
  localparam logic [7:0] A_TRANSMIT_DATA_REGS          = 8'hB5;
  localparam logic [7:0] A_SUM2_HI         = 8'hB8; // receive data in run
  localparam logic [7:0] A_SUM2_LO         = 8'hB9;
  localparam logic [7:0] A_POWER           = 8'hC0;
  localparam logic [7:0] A_MODE            = 8'hC1;
  localparam logic [7:0] A_RXCTL           = 8'hC3;
  localparam logic [7:0] A_IDENT           = 8'hC5;
  localparam logic [7:0] A_STATUS          = 8'hC6;
  localparam logic [7:0] A_PROGRAM         = 8'hC8;
  localparam logic [7:0] A_VERSION         = 8'hC9;
  localparam logic [7:0] A_MASK            = 8'hCE;
  localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
  localparam logic [15:0] DEAD_CODE        = 16'hDEAD;

  // ----------------------------------------
  // fields and sizes
  // ----------------------------------------
  localparam int ST_PRG          = 0;
  localparam int ST_RDY          = 1;
  localparam int ST_IRQ          = 15;
  localparam int MASK_ALL        = 15;
  localparam int PWR_BIAS        = 0;
  localparam int ADDR_BITS       = 8;
  localparam int FRAME_BITS      = 24;
  localparam int IMAGE_MAX_BYTES = 46 * 1024;
  localparam int IMAGE_MAX_WORDS = IMAGE_MAX_BYTES / 2;
  localparam int SAMPLE_WAIT     = 3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS         = 5;
  localparam int LINK_PERIOD_NS = 80;
  localparam int HALF_CYC       = LINK_PERIOD_NS / (2 * CLK_NS);
  localparam int TX_PHASE_CYC   = 16;

  // ----------------------------------------
  // host command port map
  // ----------------------------------------
  localparam logic [2:0] HC_LAUNCH = 3'h0;
  localparam logic [2:0] HC_WDATA  = 3'h1;
  localparam logic [2:0] HC_RDATA  = 3'h2;
  localparam logic [2:0] HC_STATE  = 3'h3;
  localparam logic [2:0] HC_BOOT   = 3'h4;
  localparam logic [2:0] HC_EXPECT = 3'h5;

  typedef enum logic [2:0] {BT_SAMPLE, BT_HOST, BT_MEM, BT_ACT, BT_RUN, BT_DEAD} boot_e;
  typedef enum logic [1:0] {MD_IDLE, MD_TX, MD_RX, MD_CS} modem_mode_e;
  typedef enum logic [2:0] {TX_OFF, TX_RAMPUP, TX_PRE, TX_SYNC, TX_PAY, TX_TAIL, TX_RAMPDN} tx_e;
endpackage : fw_boot_pkg
`default_nettype wire

// ---- fw_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fw_link_if;
  logic sel_n;
  logic sclk;
  logic cmd_data;
  logic reply_data;
  logic interrupt_request_line_n;
  logic boot_source_pin_one;
  logic boot_source_pin_two;

  modport device (
    input  sel_n, sclk, cmd_data, boot_source_pin_one, boot_source_pin_two,
    output reply_data, interrupt_request_line_n
  );
  modport host (
    output sel_n, sclk, cmd_data, boot_source_pin_one, boot_source_pin_two,
    input  reply_data, interrupt_request_line_n
  );
endinterface : fw_link_if
`default_nettype wire

// ---- fw_boot_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module fw_boot_host
  import fw_boot_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  fw_link_if.host          link,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  input  wire logic        brownout_i
);
  if (HALF < 4 || HALF > 255) begin : g_bad_half
    $error("HALF out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  typedef struct packed {
    logic [1:0]  irq_s;
    logic [1:0]  rep_s;
    logic [2:0]  bo_s;
    logic        boot1;
    logic        boot2;
    logic        busy;
    logic        sel_n;
    logic        sclk;
    logic        cdata;
    logic [23:0] frame;
    logic [15:0] rxsh;
    logic [15:0] rdres;
    logic [4:0]  bits;
    logic [7:0]  half;
    logic        is_read;
    logic [7:0]  cur;
    logic [15:0] wreg;
    logic [15:0] expect_val;
    logic        match;
    logic        refused;
    logic        prg_wait;
    logic        bo_pend;
    logic [15:0] rd_q;
  } host_s;

  host_s      r_r;
  host_s      r_nxt;
  logic       go;
  logic [7:0] go_addr;
  logic       go_read;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_nxt   = r_r;
    go      = 1'b0;
    go_addr = 8'h00;
    go_read = 1'b0;
    r_nxt.irq_s = {r_r.irq_s[0], link.interrupt_request_line_n};
    r_nxt.rep_s = {r_r.rep_s[0], link.reply_data};
    r_nxt.bo_s  = {r_r.bo_s[1:0], brownout_i};
    if (r_r.bo_s[1] && !r_r.bo_s[2]) r_nxt.bo_pend = 1'b1;

    // command port reads, data next cycle
    if (rd_i) begin
      case (addr_i)
        HC_WDATA:  r_nxt.rd_q = r_r.wreg;
        HC_RDATA:  r_nxt.rd_q = r_r.rdres;
        HC_STATE:  r_nxt.rd_q = {11'h000, ~r_r.irq_s[1], r_r.prg_wait, r_r.match, r_r.refused, r_r.busy};
        HC_BOOT:   r_nxt.rd_q = {14'h0000, r_r.boot2, r_r.boot1};
        HC_EXPECT: r_nxt.rd_q = r_r.expect_val;
        default:   r_nxt.rd_q = 16'h0000;
      endcase
      if (addr_i == HC_STATE) r_nxt.refused = 1'b0;
    end

    // command port writes
    if (wr_i) begin
      case (addr_i)
        HC_WDATA:  r_nxt.wreg = wdata_i;
        HC_BOOT: begin
          r_nxt.boot1 = wdata_i[0];
          r_nxt.boot2 = wdata_i[1];
        end
        HC_EXPECT: r_nxt.expect_val = wdata_i;
        HC_LAUNCH: begin
          if (r_r.busy || r_r.bo_pend ||
              (!wdata_i[8] && wdata_i[7:0] == A_PROGRAM && r_r.prg_wait)) begin
            r_nxt.refused = 1'b1;
          end else begin
            go      = 1'b1;
            go_addr = wdata_i[7:0];
            go_read = wdata_i[8];
            if (!wdata_i[8] && wdata_i[7:0] == A_PROGRAM) r_nxt.prg_wait = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // brownout: general reset command, pins kept for reload
    if (r_r.bo_pend && !r_r.busy) begin
      go             = 1'b1;
      go_addr        = CMD_GENERAL_RESET;
      go_read        = 1'b0;
      r_nxt.bo_pend  = 1'b0;
      r_nxt.prg_wait = 1'b0;
    end

    // launch a frame
    if (go) begin
      r_nxt.busy    = 1'b1;
      r_nxt.sel_n   = 1'b0;
      r_nxt.sclk    = 1'b0;
      r_nxt.half    = 8'h00;
      r_nxt.cur     = go_addr;
      r_nxt.is_read = go_read;
      r_nxt.frame   = {go_addr, r_r.wreg};
      r_nxt.cdata   = go_addr[7];
      r_nxt.bits    = (go_addr == CMD_GENERAL_RESET) ? 5'(ADDR_BITS) : 5'(FRAME_BITS);
    end else if (r_r.busy) begin
      r_nxt.half = r_r.half + 8'h01;
      if (r_r.half == HALF_LAST) begin
        r_nxt.half = 8'h00;
        if (!r_r.sclk) begin
          r_nxt.sclk = 1'b1;
        end else begin
          r_nxt.sclk = 1'b0;
          r_nxt.rxsh = {r_r.rxsh[14:0], r_r.rep_s[1]};
          r_nxt.bits = r_r.bits - 5'd1;
          if (r_r.bits == 5'd1) begin
            r_nxt.busy  = 1'b0;
            r_nxt.sel_n = 1'b1;
            r_nxt.cdata = 1'b0;
            if (r_r.is_read) begin
              r_nxt.rdres = {r_r.rxsh[14:0], r_r.rep_s[1]};
              r_nxt.match = ({r_r.rxsh[14:0], r_r.rep_s[1]} == r_r.expect_val);
              if (r_r.cur == A_STATUS && r_r.rep_s[1]) r_nxt.prg_wait = 1'b0;
            end
          end else begin
            r_nxt.frame = {r_r.frame[22:0], 1'b0};
            r_nxt.cdata = r_r.frame[22];
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r_r       <= '0;
      r_r.sel_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs
  assign link.sel_n               = r_r.sel_n;
  assign link.sclk                = r_r.sclk;
  assign link.cmd_data            = r_r.cdata;
  assign link.boot_source_pin_one = r_r.boot1;
  assign link.boot_source_pin_two = r_r.boot2;
  assign rdata_o                  = r_r.rd_q;
endmodule : fw_boot_host
`default_nettype wire

// ---- fw_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module fw_link_checker (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic cmd_data,
  input wire logic reply_data,
  input wire logic interrupt_request_line_n,
  input wire logic boot_source_pin_one,
  input wire logic boot_source_pin_two
);
  default clocking cb @(posedge clock_i); endclocking
  // held off one edge past reset so $past never sees pre-reset values
  logic armed_r;
  always_ff @(posedge clock_i) armed_r <= !srst_i;
  default disable iff (srst_i || !armed_r);
  // ----
  // clock rises in the current frame
  // ----
  logic [5:0] rise_r;
  always_ff @(posedge clock_i) begin
    if (srst_i || sel_n) rise_r <= 6'h00;
    else if ($rose(sclk)) rise_r <= rise_r + 6'h01;
  end
  // ----
  // link framing, bench runs a half period of 4
  // ----
  chk_idle_clk_low: assert property (sel_n |-> !sclk) else $error("sclk high outside frame");
  chk_first_lead: assert property ($fell(sel_n) |-> !sclk [*4] ##1 sclk) else $error("bad lead");
  chk_high_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("bad high");
  chk_low_len: assert property ($fell(sclk) && !sel_n |-> !sclk [*4] ##1 (sclk || sel_n))
    else $error("bad low phase");
  chk_cmd_stable: assert property ($rose(sclk) |-> $stable(cmd_data) [*4]) else $error("cmd moved");
  chk_frame_bits: assert property ($rose(sel_n) |-> rise_r == 6'h08 || rise_r == 6'h18)
    else $error("bad bit count");
  chk_boot_steady: assert property (!sel_n && !$past(sel_n) |->
    $stable({boot_source_pin_one, boot_source_pin_two})) else $error("boot pins moved");
  chk_reply_quiet: assert property (sel_n [*5] |-> !reply_data) else $error("reply while idle");
  // main scenarios seen
  cov_reset_cmd: cover property ($rose(sel_n) && rise_r == 6'h08);
  cov_long_frame: cover property ($rose(sel_n) && rise_r == 6'h18);
  cov_irq: cover property ($fell(interrupt_request_line_n));
endmodule : fw_link_checker
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fw_boot_pkg::*;
  localparam logic [15:0] PID  = 16'h5A3C; // arbitrary value
  localparam logic [31:0] CODE = 32'h1234_5678;
  logic        clock_i = 1'b0, srst_i = 1'b1, dev_rst = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, mem_data_i = 16'h0000, rx_word_i = 16'h0000, tx_word_o;
  logic        brownout_i = 1'b0, mem_req_o, mem_valid_i = 1'b0, rx_sync_i = 1'b0, rx_word_valid_i = 1'b0;
  logic        tx_word_valid_o, ready_o, cmp_now = 1'b0, cmp_d = 1'b0;
  tx_e         tx_phase_o, ph_last = TX_OFF;
  tx_e         exp_ph [7] = '{TX_RAMPUP, TX_PRE, TX_SYNC, TX_PAY, TX_TAIL, TX_RAMPDN, TX_OFF};
  modem_mode_e mode_o;
  logic [31:0] seed = 32'h0000_0299;
  logic [15:0] img [3], exp_q [$], tx_q [$];
  tx_e         ph_q [$];
  int          midx = 0, num_errors = 0, check_count = 0;
  always #2.5 clock_i = ~clock_i;
  // ----
  // the two ends and the link watcher
  // ----
  fw_link_if fw_link_if_i ();
  fw_boot_host #(.HALF(4)) fw_boot_host_i (.clock_i(clock_i), .srst_i(srst_i), .link(fw_link_if_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .brownout_i(brownout_i));
  fw_boot_device #(.PRODUCT_ID(PID), .PHASE_CYC(2)) fw_boot_device_i (.clock_i(clock_i), .srst_i(dev_rst),
    .link(fw_link_if_i), .mem_req_o(mem_req_o), .mem_data_i(mem_data_i), .mem_valid_i(mem_valid_i),
    .rx_sync_i(rx_sync_i), .rx_word_i(rx_word_i), .rx_word_valid_i(rx_word_valid_i), .tx_word_o(tx_word_o),
    .tx_word_valid_o(tx_word_valid_o), .tx_phase_o(tx_phase_o), .mode_o(mode_o), .ready_o(ready_o));
  fw_link_checker fw_link_checker_i (.clock_i(clock_i), .srst_i(srst_i), .sel_n(fw_link_if_i.sel_n),
    .sclk(fw_link_if_i.sclk), .cmd_data(fw_link_if_i.cmd_data), .reply_data(fw_link_if_i.reply_data),
    .interrupt_request_line_n(fw_link_if_i.interrupt_request_line_n),
    .boot_source_pin_one(fw_link_if_i.boot_source_pin_one), .boot_source_pin_two(fw_link_if_i.boot_source_pin_two));
  // ----
  // helpers
  // ----
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  task automatic report(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) report($sformatf("saw %h, wanted %h", seen, exp));
  endtask : check
  task automatic give_verdict();
    check(16'(exp_q.size() + tx_q.size()), 16'h0000);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // command port cycles
  task automatic hwr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : hwr
  task automatic hrd(input logic [2:0] a, input logic c, output logic [15:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    rd_i    <= 1'b1;
    cmp_now <= c;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : hrd
  // one link frame, waiting out busy
  task automatic frame(input logic [15:0] c);
    logic [15:0] s;
    hwr(HC_LAUNCH, c);
    s = 16'h0001;
    for (int i = 0; i < 300 && s[0] !== 1'b0; i++) hrd(HC_STATE, 1'b0, s);
    if (s[0] !== 1'b0) report("link stuck busy");
  endtask : frame
  task automatic dev_rd(input logic [7:0] a, output logic [15:0] d);
    frame({8'h01, a});
    hrd(HC_RDATA, 1'b0, d);
  endtask : dev_rd
  task automatic exp_rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] t;
    frame({8'h01, a});
    exp_q.push_back(e);
    hrd(HC_RDATA, 1'b1, t);
  endtask : exp_rd
  // device write, optionally polling the accepted flag
  task automatic dev_wr(input logic [7:0] a, input logic [15:0] d, input logic pw);
    logic [15:0] s;
    hwr(HC_WDATA, d);
    frame({8'h00, a});
    s = 16'h0000;
    for (int i = 0; i < 20 && pw && s[0] !== 1'b1; i++) dev_rd(A_STATUS, s);
    if (pw && s[0] !== 1'b1) report("program write not accepted");
  endtask : dev_wr
  // ----
  // serial memory feeder and output watchers
  // ----
  always @(posedge clock_i) begin
    mem_valid_i <= mem_req_o && !mem_valid_i && midx < 3;
    if (mem_req_o && !mem_valid_i && midx < 3) begin
      mem_data_i <= img[midx];
      midx <= midx + 1;
    end
    if (cmp_d) check(rdata_o, exp_q.pop_front());
    cmp_d <= rd_i & cmp_now;
    if (tx_word_valid_o === 1'b1) check(tx_word_o, tx_q.pop_front());
    if (!dev_rst && tx_phase_o !== ph_last) begin
      ph_q.push_back(tx_phase_o);
      ph_last = tx_phase_o;
    end
  end
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] v, w, d;
    logic [31:0] s1, s2;
    v = rnd();
    w = rnd();
    img = '{16'h0002, rnd(), rnd()};
    s1 = 32'(v) + 32'(w);
    s2 = (32'(v) << 1) ^ 32'(w);
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    hwr(HC_BOOT, 16'h0003);
    repeat (4) @(posedge clock_i);
    dev_rst <= 1'b0;
    repeat (10) @(posedge clock_i);
    dev_wr(A_MASK, 16'h8001, 1'b0);
    dev_wr(A_PROGRAM, 16'h0002, 1'b1);
    hrd(HC_STATE, 1'b0, d);
    check(16'(d[4]), 16'h0001);
    dev_wr(A_PROGRAM, v, 1'b1);
    dev_wr(A_PROGRAM, w, 1'b1);
    exp_rd(A_IDENT, PID);
    exp_rd(A_VERSION, v);
    exp_rd(A_SUM1_HI, s1[31:16]);
    hwr(HC_EXPECT, s1[15:0]);
    exp_rd(A_SUM1_LO, s1[15:0]);
    hrd(HC_STATE, 1'b0, d);
    check(16'(d[2]), 16'h0001);
    exp_rd(A_SUM2_HI, s2[31:16]);
    exp_rd(A_SUM2_LO, s2[15:0]);
    dev_wr(A_PROGRAM, CODE[31:16], 1'b1);
    dev_wr(A_PROGRAM, CODE[15:0], 1'b1);
    check(16'(ready_o), 16'h0001);
    check(16'(mode_o), 16'(MD_IDLE));
    exp_rd(A_IDENT, 16'h0000);
    exp_rd(A_VERSION, 16'h0000);
    exp_rd(A_SUM1_HI, 16'h0000);
    // burst out, then receive
    dev_wr(A_POWER, 16'h0001, 1'b0);
    dev_wr(A_MODE, 16'h0001, 1'b0);
    check(16'(mode_o), 16'(MD_TX));
    d = rnd();
    tx_q.push_back(d);
    dev_wr(A_TRANSMIT_DATA_REGS, d, 1'b0);
    dev_wr(A_MODE, 16'h0002, 1'b0);
    repeat (20) @(posedge clock_i);
    foreach (exp_ph[i]) check(16'(ph_q[i]), 16'(exp_ph[i]));
    d = rnd();
    @(posedge clock_i) rx_sync_i <= 1'b1;
    @(posedge clock_i) rx_sync_i <= 1'b0;
    rx_word_i <= d;
    rx_word_valid_i <= 1'b1;
    @(posedge clock_i) rx_word_valid_i <= 1'b0;
    exp_rd(A_SUM2_HI, d);
    dev_wr(A_MODE, 16'h0003, 1'b0);
    check(16'(mode_o), 16'(MD_CS));
    dev_wr(A_POWER, 16'h0000, 1'b0);
    dev_wr(A_MODE, 16'h0001, 1'b0);
    check(16'(tx_phase_o), 16'(TX_OFF));
    dev_wr(A_MODE, 16'h0000, 1'b0);
    // brownout: reload from memory, then a bad code
    hwr(HC_BOOT, 16'h0001);
    midx = 0;
    @(posedge clock_i) brownout_i <= 1'b1;
    repeat (150) @(posedge clock_i);
    brownout_i <= 1'b0;
    repeat (100) @(posedge clock_i);
    check(16'(ready_o), 16'h0000);
    exp_rd(A_VERSION, img[1]);
    check(16'(mem_req_o), 16'h0000);
    dev_wr(A_PROGRAM, ~CODE[31:16], 1'b1);
    dev_wr(A_PROGRAM, CODE[15:0], 1'b0);
    hwr(HC_LAUNCH, {8'h00, A_PROGRAM});
    hrd(HC_STATE, 1'b0, d);
    check(16'(d[1]), 16'h0001);
    repeat (20) @(posedge clock_i);
    exp_rd(A_SUM1_HI, DEAD_CODE);
    check(16'(ready_o), 16'h0000);
    repeat (2) @(posedge clock_i);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
